// ---- core/fcc_cmd_config.sv ----
// fcc_cmd_config: command behaviour and burst wrap configuration registers.
// assumes a command decoder on clk_sys presenting one opcode per cmd_valid.
`timescale 1ns/1ps
module fcc_cmd_config (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  // command port
  input  wire logic                     cmd_valid,
  input  wire logic [7:0]               cmd_opcode,
  input  wire logic [23:0]              cmd_addr,
  input  wire logic [7:0]               cmd_wdata,
  output logic                          rsp_valid_q,
  output logic [7:0]                    rsp_data_q,
  // hardware reset request from the pin logic
  input  wire logic                     hw_reset,
  output logic                          soft_reset_q,
  output logic                          clear_status_q,
  output logic                          resume_q,
  // erase engine
  input  wire logic                     last_erase_ok,
  input  wire logic                     bc_rd_valid,
  input  wire logic [7:0]               bc_rd_data,
  input  wire logic                     bc_rd_last,
  output logic                          bc_rd_req,
  output logic                          erase_start,
  output logic                          erase_skip,
  output logic                          erase_busy,
  output fcc_pkg::fcc_erase_kind_t      erase_kind,
  // program buffer load
  input  wire logic                     pg_load_start,
  input  wire logic [8:0]               pg_load_offset,
  input  wire logic                     pg_load_byte,
  output logic [8:0]                    pg_buf_addr_q,
  // array read address sequencing
  input  wire logic                     rd_start,
  input  wire logic [31:0]              rd_addr,
  input  wire logic                     rd_is_array,
  input  wire logic                     rd_is_quad_io,
  input  wire logic                     rd_next,
  output logic [31:0]                   rd_cur_addr_q,
  output logic                          rd_wrap_active_q,
  // static controls
  output logic                          parameter_sector_disable,
  output logic [2:0]                    drive_strength,
  output logic                          blank_check_en
);
  import fcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] cbnv_q;       // command_behaviour_nonvolatile
  logic [7:0] cbnv_done_q;  // bits already programmed once
  logic [7:0] bwnv_q;       // burst_wrap_boot_config
  logic [7:0] bwnv_done_q;
  logic [7:0] cbv_q;        // command_behaviour_volatile
  logic [7:0] bwv_q;        // burst_wrap_live_config
  logic       rst_armed_q;  // 66h seen, waiting for 99h
  logic       reload;       // any reset that reloads volatile copies

  // decoded strobes
  logic op_rd;
  logic op_wr;
  logic op_sbl;
  logic op_erase;
  fcc_erase_kind_t op_kind;
  logic soft_rst;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // one-time program: a bit may flip away from its default once
  function automatic logic [7:0] otp_merge(input logic [7:0] cur,
                                           input logic [7:0] done,
                                           input logic [7:0] wr,
                                           input logic [7:0] mask);
    otp_merge = (cur & (done | ~mask)) | (wr & ~done & mask);
  endfunction : otp_merge

  // which bits the write really changed, so they are frozen after
  function automatic logic [7:0] otp_used(input logic [7:0] cur,
                                          input logic [7:0] done,
                                          input logic [7:0] wr,
                                          input logic [7:0] mask);
    otp_used = done | ((cur ^ wr) & mask);
  endfunction : otp_used

  // burst length in bytes minus one, as an address mask
  function automatic logic [5:0] wrap_mask(input logic [1:0] len);
    case (len)
      2'b00:   wrap_mask = 6'h07;
      2'b01:   wrap_mask = 6'h0F;
      2'b10:   wrap_mask = 6'h1F;
      default: wrap_mask = 6'h3F;
    endcase
  endfunction : wrap_mask

  function automatic logic is_op(input logic [7:0] op, input logic [7:0] want);
    is_op = cmd_valid && (op == want);
  endfunction : is_op

  ////////////////////////////////////////////////////////////////////////////
  // opcode decode
  assign op_rd  = is_op(cmd_opcode, FCC_OP_REG_READ);
  assign op_wr  = is_op(cmd_opcode, FCC_OP_REG_WRITE);
  assign op_sbl = is_op(cmd_opcode, FCC_OP_BURST_LEN);

  // erase opcodes; block erase size bit is never consulted
  always_comb begin
    op_erase = 1'b0;
    op_kind  = FCC_ER_SECTOR;
    if (cmd_valid) begin
      case (cmd_opcode)
        FCC_OP_PARM_ERASE, FCC_OP_PARM_ERASE4: begin
          op_erase = 1'b1;
          op_kind  = FCC_ER_PARM;
        end
        FCC_OP_BLK_ERASE, FCC_OP_BLK_ERASE4: begin
          op_erase = 1'b1;             // full sector always
          op_kind  = FCC_ER_SECTOR;
        end
        FCC_OP_BULK_ERASE, FCC_OP_BULK_ERASE2: begin
          op_erase = 1'b1;
          op_kind  = FCC_ER_BULK;
        end
        default: begin
          op_erase = 1'b0;
          op_kind  = FCC_ER_SECTOR;
        end
      endcase
    end
  end

  // soft reset: legacy single opcode only when enabled, pair always
  assign soft_rst = (is_op(cmd_opcode, FCC_OP_LEGACY_RST) && cbv_q[FCC_CB_LEGRST])
                  || (is_op(cmd_opcode, FCC_OP_RST_EXEC) && rst_armed_q);
  assign reload   = soft_rst || hw_reset;

  // reset-enable latch; any other opcode disarms it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rst_armed_q <= 1'b0;
    end else if (cmd_valid) begin
      rst_armed_q <= (cmd_opcode == FCC_OP_RST_ENABLE);
    end
  end

  // soft reset pulse to the rest of the device
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= soft_rst;
    end
  end

  // 30h meaning picked by the volatile bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      resume_q       <= 1'b0;
      clear_status_q <= 1'b0;
    end else begin
      resume_q       <= is_op(cmd_opcode, FCC_OP_OP30) && cbv_q[FCC_CB_RESUME];
      clear_status_q <= is_op(cmd_opcode, FCC_OP_OP30) && !cbv_q[FCC_CB_RESUME];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nonvolatile registers; only power-on restores factory state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cbnv_q      <= FCC_CBNV_RST;
      cbnv_done_q <= 8'h00;
    end else if (op_wr && (cmd_addr == FCC_ADDR_CBNV)) begin
      cbnv_q      <= otp_merge(cbnv_q, cbnv_done_q, cmd_wdata, FCC_CB_MASK);
      cbnv_done_q <= otp_used(cbnv_q, cbnv_done_q, cmd_wdata, FCC_CB_MASK);
    end
  end

  // boot wrap register, same one-time behaviour
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bwnv_q      <= FCC_BWNV_RST;
      bwnv_done_q <= 8'h00;
    end else if (op_wr && (cmd_addr == FCC_ADDR_BWNV)) begin
      bwnv_q      <= otp_merge(bwnv_q, bwnv_done_q, cmd_wdata, FCC_BW_MASK);
      bwnv_done_q <= otp_used(bwnv_q, bwnv_done_q, cmd_wdata, FCC_BW_MASK);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // volatile command behaviour; sector map mirrors the nonvolatile bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cbv_q <= FCC_CBNV_RST;
    end else if (reload) begin
      cbv_q <= cbnv_q;
    end else begin
      if (op_wr && (cmd_addr == FCC_ADDR_CBV)) begin
        cbv_q <= (cmd_wdata & FCC_CBV_WMASK) | (cbv_q & ~FCC_CBV_WMASK);
      end
      // map bit tracks only the nonvolatile copy; host writes have no say
      cbv_q[FCC_CB_PSDIS] <= cbnv_q[FCC_CB_PSDIS];
    end
  end

  // live wrap register: generic write or set burst length
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bwv_q <= FCC_BWNV_RST;
    end else if (reload) begin
      bwv_q <= bwnv_q;
    end else if ((op_wr && (cmd_addr == FCC_ADDR_BWV)) || op_sbl) begin
      bwv_q <= cmd_wdata & FCC_BW_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read answer, one cycle after the opcode; unmapped reads zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= op_rd;
      if (op_rd) begin
        case (cmd_addr)
          FCC_ADDR_CBNV: rsp_data_q <= cbnv_q;
          FCC_ADDR_BWNV: rsp_data_q <= bwnv_q;
          FCC_ADDR_CBV:  rsp_data_q <= cbv_q;
          FCC_ADDR_BWV:  rsp_data_q <= bwv_q;
          default:       rsp_data_q <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // static controls
  assign parameter_sector_disable = cbv_q[FCC_CB_PSDIS];
  assign drive_strength           = bwv_q[7:FCC_BW_DRV_LO];
  assign blank_check_en           = cbv_q[FCC_CB_BLANK];

  ////////////////////////////////////////////////////////////////////////////
  // blank check sequencer
  fcc_blank_check u_blank_check (
    .clk_sys        (clk_sys),
    .sys_rst        (sys_rst),
    .erase_req      (op_erase),
    .erase_kind     (op_kind),
    .blank_check_en (cbv_q[FCC_CB_BLANK]),
    .last_erase_ok  (last_erase_ok),
    .rd_valid       (bc_rd_valid),
    .rd_data        (bc_rd_data),
    .rd_last        (bc_rd_last),
    .rd_req         (bc_rd_req),
    .erase_start    (erase_start),
    .erase_skip     (erase_skip),
    .busy           (erase_busy),
    .kind_q         (erase_kind)
  );

  ////////////////////////////////////////////////////////////////////////////
  // program buffer load address; wraps to offset zero past the wrap point
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pg_buf_addr_q <= 9'h000;
    end else if (pg_load_start) begin
      // in 256-byte mode the high bit is dropped so loads stay in one page
      pg_buf_addr_q <= cbv_q[FCC_CB_PGWRAP] ? pg_load_offset
                                            : {1'b0, pg_load_offset[7:0]};
    end else if (pg_load_byte) begin
      if (pg_buf_addr_q == (cbv_q[FCC_CB_PGWRAP] ? FCC_PGBUF_LAST_512
                                                 : FCC_PGBUF_LAST_256)) begin
        pg_buf_addr_q <= 9'h000;
      end else begin
        pg_buf_addr_q <= pg_buf_addr_q + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read address sequencing with burst wrap
  logic [5:0] wmask_q;

  // wrap decided at the start of each read and held for its length
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_wrap_active_q <= 1'b0;
      wmask_q          <= 6'h07;
    end else if (rd_start) begin
      rd_wrap_active_q <= !bwv_q[FCC_BW_WRAPN]  // active low
                          && rd_is_array
                          && rd_is_quad_io;
      wmask_q          <= wrap_mask(bwv_q[1:0]);
    end
  end

  // address advance; wrapped reads stay inside the aligned burst
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_cur_addr_q <= 32'h0000_0000;
    end else if (rd_start) begin
      rd_cur_addr_q <= rd_addr;
    end else if (rd_next) begin
      if (rd_wrap_active_q) begin
        rd_cur_addr_q <= {rd_cur_addr_q[31:6],
                          (rd_cur_addr_q[5:0] & ~wmask_q)
                          | ((rd_cur_addr_q[5:0] + 6'h01) & wmask_q)};
      end else begin
        rd_cur_addr_q <= rd_cur_addr_q + 32'h0000_0001;
      end
    end
  end

endmodule : fcc_cmd_config

// ---- core/fcc_pkg.sv ----
// fcc_pkg: constants shared by the flash command configuration block.
// assumes a single clock domain; opcodes arrive already decoded to bytes.
package fcc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // opcodes
  localparam logic [7:0] FCC_OP_REG_READ    = 8'h65;  // generic_register_read
  localparam logic [7:0] FCC_OP_REG_WRITE   = 8'h71;  // generic_register_write
  localparam logic [7:0] FCC_OP_BURST_LEN   = 8'hC0;  // set_burst_length_cmd
  localparam logic [7:0] FCC_OP_OP30        = 8'h30;
  localparam logic [7:0] FCC_OP_BLK_ERASE   = 8'hD8;
  localparam logic [7:0] FCC_OP_BLK_ERASE4  = 8'hDC;
  localparam logic [7:0] FCC_OP_PARM_ERASE  = 8'h20;
  localparam logic [7:0] FCC_OP_PARM_ERASE4 = 8'h21;  // plain default
  localparam logic [7:0] FCC_OP_BULK_ERASE  = 8'h60;  // plain default
  localparam logic [7:0] FCC_OP_BULK_ERASE2 = 8'hC7;  // plain default
  localparam logic [7:0] FCC_OP_LEGACY_RST  = 8'hF0;
  localparam logic [7:0] FCC_OP_RST_ENABLE  = 8'h66;
  localparam logic [7:0] FCC_OP_RST_EXEC    = 8'h99;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses inside the generic register space
  localparam logic [23:0] FCC_ADDR_CBNV = 24'h00_0004;  // command_behaviour_nonvolatile
  localparam logic [23:0] FCC_ADDR_BWNV = 24'h00_0005;  // burst_wrap_boot_config
  localparam logic [23:0] FCC_ADDR_CBV  = 24'h80_0004;  // command_behaviour_volatile
  localparam logic [23:0] FCC_ADDR_BWV  = 24'h80_0005;  // burst_wrap_live_config

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FCC_CB_BLANK  = 5;  // erase_blank_check_en
  localparam int FCC_CB_PGWRAP = 4;  // program_buffer_wrap_sel
  localparam int FCC_CB_PSDIS  = 3;  // parameter_sector_disable
  localparam int FCC_CB_RESUME = 2;  // resume_opcode_sel
  localparam int FCC_CB_BLKSZ  = 1;  // block_erase_size_sel
  localparam int FCC_CB_LEGRST = 0;  // legacy_soft_reset_en
  localparam int FCC_BW_WRAPN  = 4;  // wrap enable, active low
  localparam int FCC_BW_DRV_LO = 5;  // drive strength 7:5

  // writable bit masks; reserved bits read as zero
  localparam logic [7:0] FCC_CB_MASK   = 8'h3F;
  localparam logic [7:0] FCC_CBV_WMASK = 8'h37;  // sector map bit is read-only
  localparam logic [7:0] FCC_BW_MASK   = 8'hF3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] FCC_CBNV_RST = 8'h02;
  localparam logic [7:0] FCC_BWNV_RST = 8'h10;

  // last program buffer offset, for 256- and 512-byte buffers
  localparam logic [8:0] FCC_PGBUF_LAST_256 = 9'h0FF;
  localparam logic [8:0] FCC_PGBUF_LAST_512 = 9'h1FF;

  typedef enum logic [1:0] {
    FCC_ER_PARM,
    FCC_ER_SECTOR,
    FCC_ER_BULK
  } fcc_erase_kind_t;

endpackage : fcc_pkg

// ---- core/fcc_blank_check.sv ----
// fcc_blank_check: decides whether an erase runs, following the blank check.
// assumes the array read port answers one byte per rd_valid, rd_last on the end.
`timescale 1ns/1ps
module fcc_blank_check (
  input  wire logic                     clk_sys,
  input  wire logic                     sys_rst,
  input  wire logic                     erase_req,
  input  wire fcc_pkg::fcc_erase_kind_t erase_kind,
  input  wire logic                     blank_check_en,
  input  wire logic                     last_erase_ok,
  input  wire logic                     rd_valid,
  input  wire logic [7:0]               rd_data,
  input  wire logic                     rd_last,
  output logic                          rd_req,
  output logic                          erase_start,
  output logic                          erase_skip,
  output logic                          busy,
  output fcc_pkg::fcc_erase_kind_t      kind_q
);
  import fcc_pkg::*;

  typedef enum logic [1:0] {
    FCC_BC_IDLE,
    FCC_BC_SCAN,
    FCC_BC_START,
    FCC_BC_SKIP
  } fcc_bc_state_t;

  fcc_bc_state_t state_q;
  fcc_bc_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // next state; a zero bit ends the scan at once to save erase time
  always_comb begin
    state_d = state_q;
    case (state_q)
      FCC_BC_IDLE: begin
        if (erase_req) begin
          if (!blank_check_en) begin
            state_d = FCC_BC_START;
          end else if (!last_erase_ok) begin
            state_d = FCC_BC_START;
          end else begin
            state_d = FCC_BC_SCAN;
          end
        end
      end
      FCC_BC_SCAN: begin
        if (rd_valid && (rd_data != 8'hFF)) begin
          state_d = FCC_BC_START;
        end else if (rd_valid && rd_last) begin
          state_d = FCC_BC_SKIP;
        end
      end
      FCC_BC_START: state_d = FCC_BC_IDLE;
      FCC_BC_SKIP:  state_d = FCC_BC_IDLE;
      default:      state_d = FCC_BC_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= FCC_BC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // erase kind held for the array engine
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      kind_q <= FCC_ER_SECTOR;
    end else if (erase_req && (state_q == FCC_BC_IDLE)) begin
      kind_q <= erase_kind;
    end
  end

  // outputs
  assign rd_req      = (state_q == FCC_BC_SCAN);
  assign erase_start = (state_q == FCC_BC_START);
  assign erase_skip  = (state_q == FCC_BC_SKIP);
  assign busy        = (state_q != FCC_BC_IDLE);

endmodule : fcc_blank_check

// ---- bench/fcc_cmd_config_checker.sv ----
// checker: port properties of the configuration block
// assumes bind onto fcc_cmd_config, one clock, synchronous reset
`timescale 1ns/1ps
module fcc_cmd_config_checker (
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic       rsp_valid_q,
  input wire logic       soft_reset_q,
  input wire logic       clear_status_q,
  input wire logic       resume_q,
  input wire logic       last_erase_ok,
  input wire logic       bc_rd_valid,
  input wire logic [7:0] bc_rd_data,
  input wire logic       bc_rd_last,
  input wire logic       bc_rd_req,
  input wire logic       erase_start,
  input wire logic       erase_skip,
  input wire logic       erase_busy,
  input wire logic       rd_start,
  input wire logic       rd_is_array,
  input wire logic       rd_is_quad_io,
  input wire logic       rd_wrap_active_q,
  input wire logic       blank_check_en
);
  import fcc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  // erase opcode taken while idle
  wire er_op = cmd_valid && !erase_busy && (cmd_opcode inside {FCC_OP_PARM_ERASE,
    FCC_OP_PARM_ERASE4, FCC_OP_BLK_ERASE, FCC_OP_BLK_ERASE4, FCC_OP_BULK_ERASE,
    FCC_OP_BULK_ERASE2});
  sequence s_take; er_op; endsequence
  sequence s_op(logic [7:0] o); cmd_valid && cmd_opcode == o; endsequence
  AST_RD_ANS: assert property (s_op(FCC_OP_REG_READ) |=> rsp_valid_q)
    else $error("read not answered");
  AST_RD_CAUSE: assert property (rsp_valid_q |-> $past(cmd_valid && cmd_opcode == 8'h65))
    else $error("answer without read");
  AST_BC_OFF: assert property (s_take ##0 !blank_check_en |=> erase_start && !bc_rd_req)
    else $error("erase not started at once");
  AST_BC_FAIL: assert property (s_take ##0 blank_check_en && !last_erase_ok |=> erase_start && !bc_rd_req)
    else $error("failed sector not erased");
  AST_BC_SCAN: assert property (s_take ##0 blank_check_en && last_erase_ok |=> bc_rd_req && !erase_start)
    else $error("blank scan not begun");
  AST_BC_ZERO: assert property (bc_rd_req && bc_rd_valid && bc_rd_data != 8'hFF |=> erase_start)
    else $error("zero did not start erase");
  AST_BC_SKIP: assert property (erase_skip |-> $past(bc_rd_valid && bc_rd_last && bc_rd_data == 8'hFF))
    else $error("skip without blank end");
  AST_SR_CAUSE: assert property (soft_reset_q |-> $past(cmd_valid && cmd_opcode inside {8'hF0, 8'h99}))
    else $error("soft reset without cause");
  AST_SR_PAIR: assert property (s_op(FCC_OP_RST_ENABLE) ##1 !cmd_valid ##1 s_op(FCC_OP_RST_EXEC) |=> soft_reset_q)
    else $error("reset pair ignored");
  AST_OP30: assert property (s_op(FCC_OP_OP30) |=> resume_q != clear_status_q)
    else $error("30h gave no single pulse");
  AST_NO_WRAP: assert property (rd_start && !(rd_is_array && rd_is_quad_io) |=> !rd_wrap_active_q)
    else $error("wrap on a plain read");
endmodule : fcc_cmd_config_checker

bind fcc_cmd_config fcc_cmd_config_checker chk_u (.clk_sys, .sys_rst, .cmd_valid,
  .cmd_opcode, .rsp_valid_q, .soft_reset_q, .clear_status_q, .resume_q, .last_erase_ok,
  .bc_rd_valid, .bc_rd_data, .bc_rd_last, .bc_rd_req, .erase_start, .erase_skip,
  .erase_busy, .rd_start, .rd_is_array, .rd_is_quad_io, .rd_wrap_active_q, .blank_check_en);

// ---- bench/fcc_host_model.sv ----
// host controller model: issues one opcode per command cycle
// assumes a register read is answered one cycle later
`timescale 1ns/1ps
module fcc_host_model (
  input  wire logic        clk_sys,
  input  wire logic        rsp_valid_q,
  input  wire logic [7:0]  rsp_data_q,
  output logic             cmd_valid,
  output logic [7:0]       cmd_opcode,
  output logic [23:0]      cmd_addr,
  output logic [7:0]       cmd_wdata
);
  import fcc_pkg::*;
  logic nv_map;  // host copy of the boot sector map bit
  initial begin
    {cmd_valid, cmd_opcode, cmd_addr, cmd_wdata} = '0;
    nv_map = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one command cycle, then released fields show inverted garbage
  task send(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
            output logic v, output logic [7:0] q);
    logic [7:0] w;
    w = d;
    if (op == FCC_OP_REG_WRITE && a == FCC_ADDR_CBV) w[3] = nv_map;
    if (op == FCC_OP_REG_WRITE && a == FCC_ADDR_CBNV) nv_map = nv_map | d[3];
    @(negedge clk_sys);
    {cmd_valid, cmd_opcode, cmd_addr, cmd_wdata} = {1'b1, op, a, w};
    @(negedge clk_sys);
    v = rsp_valid_q;
    q = rsp_data_q;
    {cmd_valid, cmd_opcode, cmd_addr, cmd_wdata} = {1'b0, ~op, ~a, ~w};
  endtask : send
endmodule : fcc_host_model

// ---- bench/test_fcc_cmd_config.sv ----
// testbench: drives the configuration block and judges its ports
// assumes fcc_pkg compiled first; host model and checker on the side
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module test_fcc_cmd_config;
  import fcc_pkg::*;
  logic        clk_sys, sys_rst, cmd_valid, rsp_valid_q, hw_reset, soft_reset_q;
  logic        clear_status_q, resume_q, last_erase_ok, bc_rd_valid, bc_rd_last;
  logic        bc_rd_req, erase_start, erase_skip, erase_busy, pg_load_start;
  logic        pg_load_byte, rd_start, rd_is_array, rd_is_quad_io, rd_next, v;
  logic        rd_wrap_active_q, parameter_sector_disable, blank_check_en;
  logic [7:0]  cmd_opcode, cmd_wdata, rsp_data_q, bc_rd_data, q;
  logic [23:0] cmd_addr;
  logic [8:0]  pg_load_offset, pg_buf_addr_q;
  logic [31:0] rd_addr, rd_cur_addr_q;
  logic [2:0]  drive_strength;
  fcc_erase_kind_t erase_kind;
  int          n_mismatch, n_checks;
  fcc_cmd_config dut_u (.clk_sys, .sys_rst, .cmd_valid, .cmd_opcode, .cmd_addr,
    .cmd_wdata, .rsp_valid_q, .rsp_data_q, .hw_reset, .soft_reset_q, .clear_status_q,
    .resume_q, .last_erase_ok, .bc_rd_valid, .bc_rd_data, .bc_rd_last, .bc_rd_req,
    .erase_start, .erase_skip, .erase_busy, .erase_kind, .pg_load_start, .pg_load_offset,
    .pg_load_byte, .pg_buf_addr_q, .rd_start, .rd_addr, .rd_is_array, .rd_is_quad_io,
    .rd_next, .rd_cur_addr_q, .rd_wrap_active_q, .parameter_sector_disable,
    .drive_strength, .blank_check_en);
  fcc_host_model host_u (.clk_sys, .rsp_valid_q, .rsp_data_q, .cmd_valid, .cmd_opcode,
    .cmd_addr, .cmd_wdata);
  ////////////////////////////////////////////////////////////////////////////
  // shared command helpers
  task rd(input logic [23:0] a, input logic [7:0] e);
    host_u.send(FCC_OP_REG_READ, a, 8'h00, v, q);
    `CHK("rsp_valid_q", 1'b1, v)
    `CHK("rsp_data_q", e, q)
  endtask : rd
  task wr(input logic [23:0] a, input logic [7:0] d);
    host_u.send(FCC_OP_REG_WRITE, a, d, v, q);
  endtask : wr
  task op(input logic [7:0] o, input logic [7:0] d);
    host_u.send(o, 24'h00_0000, d, v, q);
  endtask : op
  // one sector byte; line inverted once released
  task feed(input logic [7:0] d, input logic l);
    @(negedge clk_sys);
    {bc_rd_valid, bc_rd_data, bc_rd_last} = {1'b1, d, l};
    @(negedge clk_sys);
    {bc_rd_valid, bc_rd_data, bc_rd_last} = {1'b0, ~d, 1'b0};
  endtask : feed
  task t_defaults;
    rd(FCC_ADDR_CBNV, 8'h02);
    rd(FCC_ADDR_BWNV, 8'h10);
    rd(FCC_ADDR_BWV, 8'h10);
    rd(24'h00_0003, 8'h00);  // unmapped
    `CHK("drive_strength", 3'h0, drive_strength)
  endtask : t_defaults
  task t_writes;
    wr(FCC_ADDR_CBV, 8'hF7);
    rd(FCC_ADDR_CBV, 8'h37);
    op(FCC_OP_BURST_LEN, 8'hE2);
    rd(FCC_ADDR_BWV, 8'hE2);
    `CHK("drive_strength", 3'h7, drive_strength)
    @(negedge clk_sys) hw_reset = 1'b1;
    @(negedge clk_sys) hw_reset = 1'b0;
    rd(FCC_ADDR_CBV, 8'h02);
    rd(FCC_ADDR_BWV, 8'h10);
  endtask : t_writes
  task t_soft_reset;
    wr(FCC_ADDR_CBV, 8'h01);
    op(FCC_OP_LEGACY_RST, 8'h00);
    `CHK("soft_reset_q", 1'b1, soft_reset_q)
    rd(FCC_ADDR_CBV, 8'h02);
    op(FCC_OP_LEGACY_RST, 8'h00);
    `CHK("soft_reset_q", 1'b0, soft_reset_q)
    op(FCC_OP_RST_ENABLE, 8'h00);
    op(FCC_OP_RST_EXEC, 8'h00);
    `CHK("soft_reset_q", 1'b1, soft_reset_q)
  endtask : t_soft_reset
  task t_op30;
    for (int i = 0; i < 2; i++) begin
      wr(FCC_ADDR_CBV, i ? 8'h04 : 8'h00);
      op(FCC_OP_OP30, 8'h00);
      `CHK("resume_q", i[0], resume_q)
      `CHK("clear_status_q", !i[0], clear_status_q)
    end
  endtask : t_op30
  // every kind against off, failed, dirty and blank sectors
  task t_erase;
    logic [7:0] ops [3];
    ops = '{FCC_OP_PARM_ERASE, FCC_OP_BLK_ERASE, FCC_OP_BULK_ERASE};
    for (int k = 0; k < 3; k++) begin
      for (int m = 0; m < 4; m++) begin
        wr(FCC_ADDR_CBV, m ? 8'h20 : 8'h00);
        last_erase_ok = (m >= 2);
        op(ops[k], 8'h00);
        `CHK("erase_kind", fcc_erase_kind_t'(k), erase_kind)
        `CHK("bc_rd_req", m >= 2, bc_rd_req)
        if (m == 2) feed(8'hFE, 1'b0);
        if (m == 3) feed(8'hFF, 1'b0);
        if (m == 3) feed(8'hFF, 1'b1);
        `CHK("erase_start", m != 3, erase_start)
        `CHK("erase_skip", m == 3, erase_skip)
      end
    end
  endtask : t_erase
  task t_pgwrap;
    for (int m = 0; m < 2; m++) begin
      wr(FCC_ADDR_CBV, m ? 8'h10 : 8'h00);
      @(negedge clk_sys) {pg_load_start, pg_load_offset} = {1'b1, 9'h0FF};
      @(negedge clk_sys) {pg_load_start, pg_load_byte} = 2'b01;
      @(negedge clk_sys) pg_load_byte = 1'b0;
      `CHK("pg_buf_addr_q", m ? 9'h100 : 9'h000, pg_buf_addr_q)
    end
  endtask : t_pgwrap
  // four wrap lengths, then a non-quad and a register read
  task t_rdwrap;
    logic [1:0] len;
    logic [31:0] a;
    for (int i = 0; i < 6; i++) begin
      len = (i < 4) ? i[1:0] : 2'b00;
      a = (32'h0000_0008 << len) - 32'h0000_0001;
      op(FCC_OP_BURST_LEN, {6'h00, len});
      @(negedge clk_sys) {rd_start, rd_addr, rd_is_array, rd_is_quad_io} = {1'b1, a, i != 5, i != 4};
      @(negedge clk_sys) {rd_start, rd_next} = 2'b01;
      @(negedge clk_sys) rd_next = 1'b0;
      `CHK("rd_wrap_active_q", i < 4, rd_wrap_active_q)
      `CHK("rd_cur_addr_q", (i < 4) ? 32'h0000_0000 : a + 1, rd_cur_addr_q)
    end
  endtask : t_rdwrap
  task t_nv_map;
    wr(FCC_ADDR_CBNV, 8'h08);
    @(negedge clk_sys);
    `CHK("parameter_sector_disable", 1'b1, parameter_sector_disable)
    rd(FCC_ADDR_CBV, 8'h18);
  endtask : t_nv_map
  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard
  initial begin
    #500_000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    {sys_rst, hw_reset, last_erase_ok, bc_rd_valid, bc_rd_data, bc_rd_last} = 13'h1000;
    {pg_load_start, pg_load_offset, pg_load_byte} = 11'h000;
    {rd_start, rd_addr, rd_is_array, rd_is_quad_io, rd_next} = 36'h0;
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_defaults();
    t_writes();
    t_soft_reset();
    t_op30();
    t_erase();
    t_pgwrap();
    t_rdwrap();
    t_nv_map();
    tally_and_finish();
  end
endmodule : test_fcc_cmd_config
